// ### hw/fssr_ctrl.sv
// Host controller that screens flash sectors, checks every operation and relocates failed sectors
//
// What this block does
// - Never program or erase a screened-out sector
// - Correct more than three bit errors per read
// - Read status after every program and erase
// - Rewrite a failed sector's data elsewhere
// - Block all access to a failed sector
// - Reserve about 1.8 percent spare sectors
// - Relocated data comes from buffer, not flash
// - Pick spares far from the failed sector
// - Clear status after a program or erase failure
`timescale 1ns/1ps
`include "fssr_map.svh"
`default_nettype none
module fssr_ctrl #(
	parameter int SECTOR_W = `FSSR_SECTOR_W,
	parameter int NUM_SECTORS = `FSSR_NUM_SECTORS,
	parameter int NUM_SPARE = (`FSSR_USABLE_MIN * `FSSR_SPARE_PERMILLE + 999) / 1000,
	parameter int ECC_T = `FSSR_ECC_MIN_BITS
) (
	input wire logic SYS_CLK_I,
	input wire logic SYS_RST_I,
	// User side
	input wire logic USR_REQ_I,
	input wire fssr_pkg::fssr_usr_op_e USR_OP_I,
	input wire logic [SECTOR_W-1:0] USR_SECTOR_I,
	output logic USR_READY_O,
	output logic USR_DONE_O,
	output logic USR_FAIL_O,
	output logic USR_ECC_ERR_O,
	output logic USR_RELOAD_O,
	output logic [SECTOR_W-1:0] USR_PHYS_O,
	output logic INIT_DONE_O,
	output logic SPARE_EXHAUSTED_O,
	// Flash command engine side
	output logic FL_REQ_O,
	output fssr_pkg::fssr_fl_op_e FL_OP_O,
	output logic [SECTOR_W-1:0] FL_SECTOR_O,
	output logic [11:0] FL_COL_O,
	output logic FL_SRC_BUF_O,
	input wire logic FL_DONE_I,
	input wire logic [8*`FSSR_MARKER_LEN-1:0] FL_RDATA_I,
	input wire logic [`FSSR_ECC_CNT_W-1:0] FL_ECC_ERRS_I,
	input wire logic FL_ECC_UNCORR_I
);
	import fssr_pkg::*;

	localparam logic [SECTOR_W-1:0] POOL_START = SECTOR_W'(NUM_SECTORS - NUM_SPARE);
	localparam logic [SECTOR_W-1:0] LAST_SECTOR = SECTOR_W'(NUM_SECTORS - 1);
	localparam logic [`FSSR_ECC_CNT_W-1:0] ECC_LIMIT = `FSSR_ECC_CNT_W'(ECC_T);

	fssr_state_e state;
	fssr_state_e next_state;
	fssr_usr_op_e op;
	fssr_fl_op_e cmd;
	logic [NUM_SECTORS-1:0] usable;
	logic [NUM_SECTORS-1:0] blocked;
	logic [SECTOR_W-1:0] scan;
	logic [SECTOR_W-1:0] logical;
	logic [SECTOR_W-1:0] phys;
	logic [SECTOR_W-1:0] lo_ptr;
	logic [SECTOR_W-1:0] hi_ptr;
	logic reloc;
	logic done;
	logic fail;
	logic ecc_err;

	fssr_remap_if #(.SECTOR_W(SECTOR_W)) rt ();

	fssr_remap_table #(.SECTOR_W(SECTOR_W), .ENTRIES(NUM_SPARE)) u_table (
		.clk_i(SYS_CLK_I),
		.rst_i(SYS_RST_I),
		.rt(rt)
	);

	// ----------------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------------
	wire is_idle = (state == FSSR_ST_IDLE);
	wire accept = is_idle && USR_REQ_I;
	wire [SECTOR_W-1:0] mapped = rt.hit ? rt.hit_phys : USR_SECTOR_I;
	wire is_write = (USR_OP_I != FSSR_USR_READ);
	// Requests into the spare pool, to sectors lost for want of a spare, or writes to screened-out sectors are refused
	wire refuse = (USR_SECTOR_I >= POOL_START) || blocked[USR_SECTOR_I]
		|| (is_write && !usable[mapped]);
	wire marker_ok = (FL_RDATA_I == `FSSR_MARKER_PATTERN);
	wire [7:0] status = FL_RDATA_I[7:0];
	wire st_ready = status[`FSSR_READY_BIT_POS];
	wire st_fail = (op == FSSR_USR_ERASE) ? status[`FSSR_ERASE_FAIL_BIT_POS]
		: status[`FSSR_PROGRAM_FAIL_BIT_POS];
	wire ecc_bad = FL_ECC_UNCORR_I || (FL_ECC_ERRS_I > ECC_LIMIT);
	// Spare choice: take whichever pool end lies farther from the failed sector
	wire [SECTOR_W-1:0] d_lo = (phys > lo_ptr) ? phys - lo_ptr : lo_ptr - phys;
	wire [SECTOR_W-1:0] d_hi = (phys > hi_ptr) ? phys - hi_ptr : hi_ptr - phys;
	wire take_hi = (d_hi >= d_lo);
	wire [SECTOR_W-1:0] cand = take_hi ? hi_ptr : lo_ptr;
	wire exhausted = (lo_ptr > hi_ptr);
	wire alloc_ok = (state == FSSR_ST_ALLOC) && !exhausted && usable[cand];

	assign rt.lookup_sector = is_idle ? USR_SECTOR_I : logical;
	assign rt.wr_en = alloc_ok;
	assign rt.wr_logical = logical;
	assign rt.wr_phys = cand;

	// ----------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			FSSR_ST_INIT_RD: next_state = FSSR_ST_INIT_WT;
			FSSR_ST_INIT_WT: begin
				if (FL_DONE_I) begin
					next_state = (scan == LAST_SECTOR) ? FSSR_ST_IDLE : FSSR_ST_INIT_RD;
				end
			end
			FSSR_ST_IDLE: begin
				if (USR_REQ_I) begin
					next_state = refuse ? FSSR_ST_IDLE : FSSR_ST_ISSUE;
				end
			end
			FSSR_ST_ISSUE: next_state = FSSR_ST_WAIT;
			FSSR_ST_WAIT: begin
				if (FL_DONE_I) begin
					next_state = (op == FSSR_USR_READ) ? FSSR_ST_IDLE : FSSR_ST_STAT;
				end
			end
			FSSR_ST_STAT: next_state = FSSR_ST_STAT_WT;
			FSSR_ST_STAT_WT: begin
				if (FL_DONE_I) begin
					if (!st_ready) begin
						next_state = FSSR_ST_STAT;
					end else begin
						next_state = st_fail ? FSSR_ST_CLEAR : FSSR_ST_IDLE;
					end
				end
			end
			FSSR_ST_CLEAR: next_state = FSSR_ST_CLEAR_WT;
			FSSR_ST_CLEAR_WT: begin
				if (FL_DONE_I) begin
					next_state = FSSR_ST_ALLOC;
				end
			end
			FSSR_ST_ALLOC: begin
				if (exhausted) begin
					next_state = FSSR_ST_IDLE;
				end else if (usable[cand]) begin
					next_state = FSSR_ST_ISSUE;
				end
			end
			default: next_state = FSSR_ST_INIT_RD;
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			state <= FSSR_ST_INIT_RD;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------------
	// Flash command register
	// ----------------------------------------------------------------------
	wire [SECTOR_W-1:0] cmd_sector = (next_state == FSSR_ST_INIT_RD) ? scan + SECTOR_W'(1)
		: alloc_ok ? cand : accept ? mapped : phys;
	wire fssr_usr_op_e op_sel = accept ? USR_OP_I : op;

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			cmd <= FSSR_FL_MARKER;
			FL_SECTOR_O <= '0;
		end else begin
			FL_SECTOR_O <= cmd_sector;
			case (next_state)
				FSSR_ST_INIT_RD: cmd <= FSSR_FL_MARKER;
				FSSR_ST_STAT: cmd <= FSSR_FL_STATUS;
				FSSR_ST_CLEAR: cmd <= FSSR_FL_CLEAR;
				FSSR_ST_ISSUE: begin
					cmd <= (op_sel == FSSR_USR_READ) ? FSSR_FL_READ
						: (op_sel == FSSR_USR_ERASE) ? FSSR_FL_ERASE : FSSR_FL_PROGRAM;
				end
				default: cmd <= cmd;
			endcase
		end
	end

	assign FL_OP_O = cmd;
	assign FL_REQ_O = (state == FSSR_ST_INIT_RD) || (state == FSSR_ST_ISSUE)
		|| (state == FSSR_ST_STAT) || (state == FSSR_ST_CLEAR);
	assign FL_COL_O = (cmd == FSSR_FL_MARKER) ? `FSSR_MARKER_COL : 12'h000;
	assign FL_SRC_BUF_O = reloc;

	// ----------------------------------------------------------------------
	// Screening, retirement and spare pointers
	// ----------------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			usable <= '0;
			scan <= '0;
		end else if (state == FSSR_ST_INIT_WT && FL_DONE_I) begin
			usable[scan] <= marker_ok;
			scan <= scan + SECTOR_W'(1);
		end else if (state == FSSR_ST_STAT_WT && FL_DONE_I && st_ready && st_fail) begin
			usable[phys] <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			lo_ptr <= POOL_START;
			hi_ptr <= LAST_SECTOR;
		end else if (state == FSSR_ST_ALLOC && !exhausted) begin
			// A used or unusable candidate is stepped over either way
			if (take_hi) begin
				hi_ptr <= hi_ptr - SECTOR_W'(1);
			end else begin
				lo_ptr <= lo_ptr + SECTOR_W'(1);
			end
		end
	end

	// Without a spare the logical sector is lost and capacity shrinks
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			blocked <= '0;
		end else if (state == FSSR_ST_ALLOC && exhausted) begin
			blocked[logical] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------------
	// Transfer context
	// ----------------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			op <= FSSR_USR_READ;
			logical <= '0;
			phys <= '0;
			reloc <= 1'b0;
		end else if (accept) begin
			op <= USR_OP_I;
			logical <= USR_SECTOR_I;
			phys <= mapped;
			reloc <= 1'b0;
		end else if (alloc_ok) begin
			phys <= cand;
			reloc <= (op == FSSR_USR_PROGRAM);
		end
	end

	// ----------------------------------------------------------------------
	// User answer
	// ----------------------------------------------------------------------
	wire fin_refuse = accept && refuse;
	wire fin_read = (state == FSSR_ST_WAIT) && FL_DONE_I && (op == FSSR_USR_READ);
	wire fin_ok = (state == FSSR_ST_STAT_WT) && FL_DONE_I && st_ready && !st_fail;
	wire fin_lost = (state == FSSR_ST_ALLOC) && exhausted;

	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			done <= 1'b0;
			fail <= 1'b0;
			ecc_err <= 1'b0;
			USR_PHYS_O <= '0;
		end else begin
			done <= fin_refuse || fin_read || fin_ok || fin_lost;
			fail <= fin_refuse || fin_lost;
			ecc_err <= fin_read && ecc_bad;
			USR_PHYS_O <= phys;
		end
	end

	assign USR_DONE_O = done;
	assign USR_FAIL_O = fail;
	assign USR_ECC_ERR_O = ecc_err;
	assign USR_READY_O = is_idle;
	assign USR_RELOAD_O = alloc_ok && (op == FSSR_USR_PROGRAM);
	assign INIT_DONE_O = (state != FSSR_ST_INIT_RD) && (state != FSSR_ST_INIT_WT);
	assign SPARE_EXHAUSTED_O = exhausted;

endmodule
`default_nettype wire

// ### hw/fssr_map.svh
// Offsets, field positions, patterns and sizing constants of the sector screen and remap controller
`ifndef FSSR_MAP_SVH
`define FSSR_MAP_SVH

// ----------------------------------------------------------------------
// Factory marker in the spare area of every usable sector
// ----------------------------------------------------------------------
`define FSSR_MARKER_COL 12'h820
`define FSSR_MARKER_LEN 6
`define FSSR_MARKER_PATTERN 48'h1c71c71c71c7

// ----------------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------------
`define FSSR_READY_BIT_POS 7
`define FSSR_ERASE_FAIL_BIT_POS 5
`define FSSR_PROGRAM_FAIL_BIT_POS 4

// ----------------------------------------------------------------------
// Sizing
// ----------------------------------------------------------------------
`define FSSR_SECTOR_W 14
`define FSSR_NUM_SECTORS 16384
`define FSSR_USABLE_MIN 16057
`define FSSR_SPARE_PERMILLE 18
`define FSSR_ECC_MIN_BITS 4
`define FSSR_ECC_CNT_W 4

`endif

// ### hw/fssr_pkg.sv
// Types shared by the sector screen and remap controller
package fssr_pkg;

	// ----------------------------------------------------------------------
	// Operations asked of the flash command engine
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {
		FSSR_FL_READ = 3'h0,
		FSSR_FL_PROGRAM = 3'h1,
		FSSR_FL_ERASE = 3'h2,
		FSSR_FL_STATUS = 3'h3,
		FSSR_FL_CLEAR = 3'h4,
		FSSR_FL_MARKER = 3'h5
	} fssr_fl_op_e;

	// ----------------------------------------------------------------------
	// Operations asked by the user
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {
		FSSR_USR_READ = 2'h0,
		FSSR_USR_PROGRAM = 2'h1,
		FSSR_USR_ERASE = 2'h2
	} fssr_usr_op_e;

	// ----------------------------------------------------------------------
	// Controller states, one-hot
	// ----------------------------------------------------------------------
	typedef enum logic [9:0] {
		FSSR_ST_INIT_RD = 10'h001,
		FSSR_ST_INIT_WT = 10'h002,
		FSSR_ST_IDLE = 10'h004,
		FSSR_ST_ISSUE = 10'h008,
		FSSR_ST_WAIT = 10'h010,
		FSSR_ST_STAT = 10'h020,
		FSSR_ST_STAT_WT = 10'h040,
		FSSR_ST_CLEAR = 10'h080,
		FSSR_ST_CLEAR_WT = 10'h100,
		FSSR_ST_ALLOC = 10'h200
	} fssr_state_e;

endpackage

// ### hw/fssr_remap_if.sv
// Link between the controller and its remap table
`timescale 1ns/1ps
`default_nettype none
interface fssr_remap_if #(parameter int SECTOR_W = 14);
	logic [SECTOR_W-1:0] lookup_sector;
	logic hit;
	logic [SECTOR_W-1:0] hit_phys;
	logic wr_en;
	logic [SECTOR_W-1:0] wr_logical;
	logic [SECTOR_W-1:0] wr_phys;

	modport table_end (input lookup_sector, output hit, output hit_phys,
		input wr_en, input wr_logical, input wr_phys);
	modport ctrl_end (output lookup_sector, input hit, input hit_phys,
		output wr_en, output wr_logical, output wr_phys);
endinterface
`default_nettype wire

// ### hw/fssr_remap_table.sv
// Table that redirects retired logical sectors to their spare sectors
`timescale 1ns/1ps
`default_nettype none
module fssr_remap_table #(
	parameter int SECTOR_W = 14,
	parameter int ENTRIES = 290
) (
	input wire logic clk_i,
	input wire logic rst_i,
	fssr_remap_if.table_end rt
);
	import fssr_pkg::*;

	localparam int IDX_W = $clog2(ENTRIES + 1);

	logic [ENTRIES-1:0] valid;
	logic [ENTRIES-1:0] match_lk;
	logic [ENTRIES-1:0] match_wr;
	logic [SECTOR_W-1:0] logical [ENTRIES];
	logic [SECTOR_W-1:0] phys [ENTRIES];
	logic [IDX_W-1:0] fill;
	logic any_wr_hit;
	logic append;

	assign any_wr_hit = |match_wr;
	assign append = rt.wr_en && !any_wr_hit && (fill < IDX_W'(ENTRIES));

	// ----------------------------------------------------------------------
	// Entries: a second failure of the same logical sector overwrites its entry
	// ----------------------------------------------------------------------
	for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
		assign match_lk[i] = valid[i] && (logical[i] == rt.lookup_sector);
		assign match_wr[i] = valid[i] && (logical[i] == rt.wr_logical);
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				valid[i] <= 1'b0;
				logical[i] <= '0;
				phys[i] <= '0;
			end else if (rt.wr_en && (match_wr[i] || (append && fill == IDX_W'(i)))) begin
				valid[i] <= 1'b1;
				logical[i] <= rt.wr_logical;
				phys[i] <= rt.wr_phys;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fill <= '0;
		end else if (append) begin
			fill <= fill + IDX_W'(1);
		end
	end

	// ----------------------------------------------------------------------
	// Lookup: at most one entry matches, so an OR of masked entries serves
	// ----------------------------------------------------------------------
	always_comb begin
		rt.hit_phys = '0;
		for (int j = 0; j < ENTRIES; j++) begin
			if (match_lk[j]) begin
				rt.hit_phys = rt.hit_phys | phys[j];
			end
		end
	end
	assign rt.hit = |match_lk;

endmodule
`default_nettype wire

// ### tb/fssr_ctrl_properties.sv
// Port-level checks of the sector screen and remap controller
`timescale 1ns/1ps
`default_nettype none
module fssr_ctrl_properties #(parameter int ECC_T = 4) (
	input wire logic SYS_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic USR_DONE_O,
	input wire logic USR_FAIL_O,
	input wire logic USR_ECC_ERR_O,
	input wire logic USR_RELOAD_O,
	input wire logic INIT_DONE_O,
	input wire logic FL_REQ_O,
	input wire fssr_pkg::fssr_fl_op_e FL_OP_O,
	input wire logic [11:0] FL_COL_O,
	input wire logic FL_SRC_BUF_O,
	input wire logic FL_DONE_I,
	input wire logic [47:0] FL_RDATA_I,
	input wire logic [3:0] FL_ECC_ERRS_I,
	input wire logic FL_ECC_UNCORR_I
);
	import fssr_pkg::*;
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	wire st_done = FL_DONE_I && FL_OP_O == FSSR_FL_STATUS;
	wire pe_done = FL_DONE_I && (FL_OP_O == FSSR_FL_PROGRAM || FL_OP_O == FSSR_FL_ERASE);
	wire st_fail = st_done && FL_RDATA_I[7] && (FL_RDATA_I[5] || FL_RDATA_I[4]);
	wire st_pass = st_done && FL_RDATA_I[7] && !FL_RDATA_I[5] && !FL_RDATA_I[4];
	wire rd_done = FL_DONE_I && FL_OP_O == FSSR_FL_READ;
	wire ecc_bad = FL_ECC_UNCORR_I || int'(FL_ECC_ERRS_I) > ECC_T;
	// A command stays open from its request until the engine answers
	logic cmd_open;
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			cmd_open <= 1'b0;
		end else if (FL_REQ_O) begin
			cmd_open <= 1'b1;
		end else if (FL_DONE_I) begin
			cmd_open <= 1'b0;
		end
	end
	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	marker_col_a: assert property (FL_REQ_O && FL_OP_O == FSSR_FL_MARKER |-> FL_COL_O == 12'h820)
		else $error("marker read at wrong column");
	init_marker_a: assert property (FL_REQ_O && !INIT_DONE_O |-> FL_OP_O == FSSR_FL_MARKER)
		else $error("non-marker command during screening");
	status_follow_a: assert property (pe_done |=> FL_REQ_O && FL_OP_O == FSSR_FL_STATUS)
		else $error("no status read after program or erase");
	busy_reread_a: assert property (st_done && !FL_RDATA_I[7] |=> FL_REQ_O && FL_OP_O == FSSR_FL_STATUS)
		else $error("busy status not polled again");
	fail_clear_a: assert property (st_fail |=> FL_REQ_O && FL_OP_O == FSSR_FL_CLEAR)
		else $error("failure not followed by status clear");
	pass_done_a: assert property (st_pass |=> USR_DONE_O && !USR_FAIL_O)
		else $error("passing status did not finish request");
	ecc_report_a: assert property (rd_done |=> USR_DONE_O && USR_ECC_ERR_O == $past(ecc_bad))
		else $error("read error flag wrong");
	reload_src_a: assert property (USR_RELOAD_O |=> FL_REQ_O && FL_OP_O == FSSR_FL_PROGRAM && FL_SRC_BUF_O)
		else $error("relocated program not from buffer");
	one_cmd_a: assert property (FL_REQ_O |-> !cmd_open)
		else $error("second command while one outstanding");
	req_pulse_a: assert property (FL_REQ_O |=> !FL_REQ_O)
		else $error("command request longer than one cycle");
	cover property (st_fail);
	cover property (USR_RELOAD_O);
	cover property (rd_done && ecc_bad);
endmodule
bind fssr_ctrl fssr_ctrl_properties #(.ECC_T(ECC_T)) u_fssr_ctrl_properties (.*);
`default_nettype wire

// ### tb/fssr_flash_model.sv
// Behavioural flash command engine with marker, status and failure injection
`timescale 1ns/1ps
`default_nettype none
module fssr_flash_model #(parameter int SW = 4) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire fssr_pkg::fssr_fl_op_e op_i,
	input wire logic [SW-1:0] sector_i,
	input wire logic fail_en_i,
	input wire logic [SW-1:0] fail_sector_i,
	output logic done_o,
	output logic [47:0] rdata_o
);
	import fssr_pkg::*;
	fssr_fl_op_e op = FSSR_FL_READ;
	logic [SW-1:0] sec = '0;
	logic [1:0] cnt = 2'h0;
	logic busy = 1'b0;
	logic polled = 1'b0;
	logic failed = 1'b0;
	logic erase = 1'b0;
	logic [47:0] data = 48'h0;
	initial done_o = 1'b0;
	// Sectors 5 and 13 carry a broken marker: one user sector, one spare
	wire bad = sec == SW'(5) || sec == SW'(13);
	// First poll after an operation reports busy
	wire [7:0] status = polled ? {2'b10, erase & failed, ~erase & failed, 4'h0} : 8'h00;
	// Released bus shows the inverse so stale data cannot pass
	assign rdata_o = done_o ? data : ~data;
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (rst_i) begin
			busy <= 1'b0;
			polled <= 1'b0;
		end else if (req_i) begin
			op <= op_i;
			sec <= sector_i;
			busy <= 1'b1;
			cnt <= sector_i[1:0];
		end else if (busy && cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end else if (busy) begin
			busy <= 1'b0;
			done_o <= 1'b1;
			case (op)
				FSSR_FL_MARKER: data <= bad ? 48'h1c71c71c71c6 : 48'h1c71c71c71c7;
				FSSR_FL_STATUS: begin
					data <= {40'h0, status};
					polled <= 1'b1;
				end
				FSSR_FL_PROGRAM, FSSR_FL_ERASE: begin
					polled <= 1'b0;
					erase <= op == FSSR_FL_ERASE;
					failed <= fail_en_i && sec == fail_sector_i;
				end
				default: data <= 48'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench of the sector screen and remap controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fssr_pkg::*;
	localparam int SW = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req = 1'b0;
	fssr_usr_op_e op = FSSR_USR_READ;
	logic [SW-1:0] sector = '0;
	logic fail_en = 1'b0;
	logic [SW-1:0] fail_sector = '0;
	logic [3:0] ecc_errs = 4'h0;
	logic ecc_uncorr = 1'b0;
	int fail_count = 0;
	int total_checks = 0;
	logic ready, done, fail, ecc_err, reload, init_done, exhausted, fl_req, src_buf, fl_done;
	logic [SW-1:0] phys, fl_sector;
	fssr_fl_op_e fl_op;
	logic [47:0] fl_rdata;
	logic g_fail, g_ecc, g_reload, g_src, g_fl;
	logic [SW-1:0] g_phys;
	fssr_ctrl #(.SECTOR_W(SW), .NUM_SECTORS(16), .NUM_SPARE(4)) u_fssr_ctrl (.SYS_CLK_I(clk),
		.SYS_RST_I(rst), .USR_REQ_I(req), .USR_OP_I(op), .USR_SECTOR_I(sector), .USR_READY_O(ready),
		.USR_DONE_O(done), .USR_FAIL_O(fail), .USR_ECC_ERR_O(ecc_err), .USR_RELOAD_O(reload),
		.USR_PHYS_O(phys), .INIT_DONE_O(init_done), .SPARE_EXHAUSTED_O(exhausted), .FL_REQ_O(fl_req),
		.FL_OP_O(fl_op), .FL_SECTOR_O(fl_sector), .FL_COL_O(), .FL_SRC_BUF_O(src_buf), .FL_DONE_I(fl_done),
		.FL_RDATA_I(fl_rdata), .FL_ECC_ERRS_I(ecc_errs), .FL_ECC_UNCORR_I(ecc_uncorr));
	fssr_flash_model #(.SW(SW)) u_fssr_flash_model (.clk_i(clk), .rst_i(rst), .req_i(fl_req), .op_i(fl_op),
		.sector_i(fl_sector), .fail_en_i(fail_en), .fail_sector_i(fail_sector), .done_o(fl_done),
		.rdata_o(fl_rdata));
	initial begin
		forever #4 clk = ~clk;
	end
	// ----------------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------------
	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic chk_sec(input logic [SW-1:0] got, input logic [SW-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: sector %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// One user request; outputs are sampled at falling edges where they are settled
	task automatic do_op(input fssr_usr_op_e o, input logic [SW-1:0] s);
		int n;
		n = 0;
		@(negedge clk);
		op = o;
		sector = s;
		req = 1'b1;
		{g_reload, g_src, g_fl} = 3'b000;
		do begin
			@(negedge clk);
			req = 1'b0;
			n++;
			g_reload |= reload === 1'b1;
			g_src |= src_buf === 1'b1;
			g_fl |= fl_req === 1'b1;
		end while (done !== 1'b1 && n < 300);
		{g_fail, g_ecc, g_phys} = {fail, ecc_err, phys};
		chk_bit(done, 1'b1);
		chk_bit(ready, 1'b1);
	endtask
	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	task automatic t_init;
		int n;
		for (n = 0; n < 400 && init_done !== 1'b1; n++) @(negedge clk);
		chk_bit(init_done, 1'b1);
	endtask
	task automatic t_refuse;
		do_op(FSSR_USR_PROGRAM, 4'h5);
		chk_bit(g_fail, 1'b1);
		chk_bit(g_fl, 1'b0);
		do_op(FSSR_USR_ERASE, 4'hc);
		chk_bit(g_fail, 1'b1);
		do_op(FSSR_USR_READ, 4'h5);
		chk_bit(g_fail, 1'b0);
		chk_sec(g_phys, 4'h5);
	endtask
	task automatic t_ecc;
		logic [3:0] errs [3] = '{4'h4, 4'h5, 4'h0};
		logic unc [3] = '{1'b0, 1'b0, 1'b1};
		logic exp [3] = '{1'b0, 1'b1, 1'b1};
		for (int i = 0; i < 3; i++) begin
			ecc_errs = errs[i];
			ecc_uncorr = unc[i];
			do_op(FSSR_USR_READ, 4'h2);
			chk_bit(g_ecc, exp[i]);
		end
		{ecc_errs, ecc_uncorr} = 5'h00;
	endtask
	task automatic t_pass;
		do_op(FSSR_USR_PROGRAM, 4'h1);
		chk_bit(g_fail, 1'b0);
		chk_bit(g_reload, 1'b0);
		chk_sec(g_phys, 4'h1);
	endtask
	task automatic t_reloc;
		fail_en = 1'b1;
		fail_sector = 4'h2;
		do_op(FSSR_USR_ERASE, 4'h2);
		chk_bit(g_reload, 1'b0);
		chk_sec(g_phys, 4'hf);
		fail_sector = 4'ha;
		do_op(FSSR_USR_PROGRAM, 4'ha);
		chk_bit(g_reload, 1'b1);
		chk_bit(g_src, 1'b1);
		chk_sec(g_phys, 4'he);
		fail_en = 1'b0;
		do_op(FSSR_USR_READ, 4'h2);
		chk_sec(g_phys, 4'hf);
	endtask
	task automatic t_exhaust;
		fail_en = 1'b1;
		fail_sector = 4'h0;
		do_op(FSSR_USR_PROGRAM, 4'h0);
		chk_sec(g_phys, 4'hc);
		fail_sector = 4'h3;
		do_op(FSSR_USR_ERASE, 4'h3);
		chk_bit(g_fail, 1'b1);
		chk_bit(exhausted, 1'b1);
		fail_en = 1'b0;
		do_op(FSSR_USR_READ, 4'h3);
		chk_bit(g_fail, 1'b1);
		chk_bit(g_fl, 1'b0);
	endtask
	initial begin
		#100us;
		fail_count++;
		final_report();
	end
	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_init();
		t_refuse();
		t_ecc();
		t_pass();
		t_reloc();
		t_exhaust();
		final_report();
	end
endmodule
`default_nettype wire
